// File: testbench/hvc_bus_ctrl.sv
`timescale 1ns/10ps
`default_nettype none

module hvc_bus_ctrl (
	output logic scl,
	output logic sdaLow,
	input wire logic sda
);
	// ****
	// Two-wire controller, clock idles high between frames
	// ****
	int slow = 0;

	initial begin
		scl = 1'b1;
		sdaLow = 1'b0;
	end

	// Extra low time stands in for a slow controller
	task automatic bitx(input logic b, output logic r);
		#(4 + slow) sdaLow = !b;
		#12 scl = 1'b1;
		#15 r = sda;
		#1 scl = 1'b0;
	endtask

	task automatic start();
		if (!scl) begin
			#4 sdaLow = 1'b0;
			#12 scl = 1'b1;
		end
		#12 sdaLow = 1'b1;
		#16 scl = 1'b0;
	endtask

	task automatic stop();
		#4 sdaLow = 1'b1;
		#12 scl = 1'b1;
		#12 sdaLow = 1'b0;
		#16;
	endtask

	task automatic wrByte(input logic [7:0] d, output logic ack);
		for (int i = 7; i >= 0; i--) bitx(d[i], ack);
		bitx(1'b1, ack);
	endtask

	task automatic rdByte(input logic ackOut, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
		bitx(ackOut, r);
	endtask
endmodule

`default_nettype wire

// File: testbench/hvc_serial_target_asserts.sv
`timescale 1ns/10ps
`default_nettype none

module hvc_serial_target_asserts (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic serialClk,
	input wire logic serialDataIn,
	input wire logic serialDataOut,
	input wire logic serialDataOe,
	input wire logic muteLeft,
	input wire logic muteRight,
	input wire logic [hvc_pkg::VOL_W-1:0] volumeCode,
	input wire logic signed [hvc_pkg::GAIN_W-1:0] gainLeft,
	input wire logic signed [hvc_pkg::GAIN_W-1:0] gainRight,
	input wire logic settingUpdated,
	input wire logic targetSelected,
	input wire logic transferEnded
);
	// ****
	// Link and output checks
	// ****
	logic oeAtRise;

	// Reset clear, so the first falling clock of a frame never compares against an unknown
	always_ff @(posedge serialClk or posedge rst) begin
		if (rst) begin
			oeAtRise <= 1'b0;
		end else begin
			oeAtRise <= serialDataOe;
		end
	end

	property p_out_low;
		@(posedge sys_clk) disable iff (rst) serialDataOut == 1'b0;
	endproperty
	a_out_low: assert property (p_out_low) else $error("sda driven high");

	property p_oe_steady;
		@(negedge serialClk) disable iff (rst) serialDataOe == oeAtRise;
	endproperty
	a_oe_steady: assert property (p_oe_steady) else $error("sda moved with clock high");

	property p_reset_state;
		@(posedge sys_clk) rst ##1 rst |-> muteLeft && muteRight && volumeCode == 6'h00
			&& gainLeft == hvc_pkg::MUTE_GAIN;
	endproperty
	a_reset_state: assert property (p_reset_state) else $error("bad reset state");

	property p_mute_left;
		@(posedge sys_clk) disable iff (rst) muteLeft [*3] |-> gainLeft == hvc_pkg::MUTE_GAIN;
	endproperty
	a_mute_left: assert property (p_mute_left) else $error("left mute gain");

	property p_mute_right;
		@(posedge sys_clk) disable iff (rst) muteRight [*3] |-> gainRight == hvc_pkg::MUTE_GAIN;
	endproperty
	a_mute_right: assert property (p_mute_right) else $error("right mute gain");

	property p_floor;
		@(posedge sys_clk) disable iff (rst)
			(!muteLeft && volumeCode == 6'h00) [*3] |-> gainLeft == 11'sh5ad;
	endproperty
	a_floor: assert property (p_floor) else $error("lowest step gain");

	property p_top;
		@(posedge sys_clk) disable iff (rst)
			(!muteRight && volumeCode == 6'h3f) [*3] |-> gainRight == 11'sh028;
	endproperty
	a_top: assert property (p_top) else $error("highest step gain");

	property p_hold;
		@(posedge sys_clk) disable iff (rst)
			!settingUpdated |-> $stable({muteLeft, muteRight, volumeCode});
	endproperty
	a_hold: assert property (p_hold) else $error("setting moved without write");
endmodule

bind hvc_serial_target hvc_serial_target_asserts chk (.sys_clk, .rst, .serialClk, .serialDataIn,
	.serialDataOut, .serialDataOe, .muteLeft, .muteRight, .volumeCode, .gainLeft, .gainRight,
	.settingUpdated, .targetSelected, .transferEnded);

`default_nettype wire

// File: testbench/tb_headphone_volume_serial_control.sv
`timescale 1ns/10ps
`default_nettype none

module tb_headphone_volume_serial_control;
	// ****
	// Bench
	// ****
	logic sys_clk, rst, serialClk, serialDataIn, serialDataOe, sdaLow, muteLeft, muteRight;
	logic settingUpdated, targetSelected, transferEnded;
	logic [hvc_pkg::VOL_W-1:0] volumeCode;
	logic signed [hvc_pkg::GAIN_W-1:0] gainLeft, gainRight;
	int err_count = 0;
	int checks = 0;
	int selCnt = 0;
	int updCnt = 0;
	int endCnt = 0;

	// Pull-up: released line reads high
	assign serialDataIn = !(sdaLow || serialDataOe);

	hvc_serial_target dut (.sys_clk, .rst, .serialClk, .serialDataIn, .serialDataOut(),
		.serialDataOe, .muteLeft, .muteRight, .volumeCode, .gainLeft, .gainRight,
		.settingUpdated, .targetSelected, .transferEnded);
	hvc_bus_ctrl bus (.scl(serialClk), .sdaLow, .sda(serialDataIn));

	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	// Pulses sampled mid-cycle; an unknown pulse is never counted
	always @(negedge sys_clk) begin
		if (targetSelected === 1'b1) selCnt++;
		if (settingUpdated === 1'b1) updCnt++;
		if (transferEnded === 1'b1) endCnt++;
	end

	task automatic chkCnt(input int got, input int exp);
		checks++;
		if (got != exp) begin
			err_count++;
			$display("[ERR] %0t count %0d exp %0d", $time, got, exp);
		end
	endtask

	task automatic chkV(input logic [10:0] g, input logic [10:0] e);
		checks++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask

	// Bytes sent first-highest: index byte, then data bytes
	task automatic xfer(input logic [6:0] a, input logic [31:0] q, input int n,
		input logic ackExp);
		logic ack;
		logic [7:0] idx;
		int sel0;
		int upd0;
		int end0;
		int updExp;
		sel0 = selCnt;
		upd0 = updCnt;
		end0 = endCnt;
		updExp = 0;
		idx = q[8*(n-1) +: 8];
		bus.start();
		bus.wrByte({a, 1'b0}, ack);
		chkV(11'(ack), 11'(ackExp));
		for (int i = 0; i < n; i++) begin
			bus.wrByte(q[8*(n-1-i) +: 8], ack);
			chkV(11'(ack), 11'(ackExp));
			if (i > 0 && idx + 8'(i - 1) == hvc_pkg::VOL_REG_INDEX && !ackExp) updExp++;
		end
		bus.stop();
		for (int k = 0; k < 12 && transferEnded !== 1'b1; k++) @(posedge sys_clk);
		repeat (3) @(posedge sys_clk);
		#1;
		chkCnt(selCnt - sel0, ackExp ? 0 : 1);
		chkCnt(updCnt - upd0, updExp);
		chkCnt(endCnt - end0, 1);
	endtask

	task automatic t_write();
		chkV(11'({muteLeft, muteRight, volumeCode}), 11'h0c0);
		xfer(7'h2a, 32'h0000023f, 2, 1'b0);
		chkV(11'({muteLeft, muteRight, volumeCode}), 11'h03f);
		chkV(gainRight, 11'h028);
		// Index 1 and 3 are acked but dropped; only index 2 lands
		xfer(7'h2a, 32'h015520ff, 4, 1'b0);
		chkV(11'({muteLeft, muteRight, volumeCode}), 11'h020);
		chkV(gainLeft, 11'h793);
		$display("test write done");
	endtask

	task automatic t_read();
		logic ack;
		logic [7:0] d;
		int sel0;
		int end0;
		sel0 = selCnt;
		end0 = endCnt;
		bus.start();
		bus.wrByte(8'h54, ack);
		chkV(11'(ack), 11'h000);
		bus.wrByte(8'h02, ack);
		chkV(11'(ack), 11'h000);
		bus.start();
		bus.wrByte(8'h55, ack);
		chkV(11'(ack), 11'h000);
		bus.rdByte(1'b0, d);
		chkV(11'(d), 11'h020);
		// Controller acked, so the next index is sent; it is unmapped
		bus.rdByte(1'b1, d);
		chkV(11'(d), 11'h000);
		bus.stop();
		repeat (8) @(posedge sys_clk);
		#1;
		chkCnt(selCnt - sel0, 2);
		chkCnt(endCnt - end0, 1);
		$display("test read done");
	endtask

	task automatic t_foreign();
		xfer(7'h2b, 32'h000002c5, 2, 1'b1);
		chkV(11'({muteLeft, muteRight, volumeCode}), 11'h020);
		xfer(7'h2a, 32'h00000200, 2, 1'b0);
		chkV(gainLeft, 11'h5ad);
		$display("test foreign done");
	endtask

	task automatic t_mute();
		bus.slow = 40;
		xfer(7'h2a, 32'h000002c5, 2, 1'b0);
		bus.slow = 0;
		chkV(11'(volumeCode), 11'h005);
		chkV(gainLeft, 11'h418);
		chkV(gainRight, 11'h418);
		$display("test mute done");
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	initial begin
		// Low first, so the asynchronous link flops see a real rising reset
		rst = 1'b0;
		#1 rst = 1'b1;
		repeat (4) @(posedge sys_clk);
		#1 rst = 1'b0;
		@(posedge sys_clk);
		#1;
		t_write();
		t_read();
		t_foreign();
		t_mute();
		test_done();
	end

	initial begin
		#200000;
		err_count++;
		test_done();
	end
endmodule

`default_nettype wire

// File: verilog/hvc_gain_rom.sv
`timescale 1ns/10ps
`default_nettype none

module hvc_gain_rom (
	input wire logic clk,
	input wire logic [hvc_pkg::VOL_W-1:0] index,
	output logic signed [hvc_pkg::GAIN_W-1:0] gain
);

	// ****************************************
	// Audio taper, code 0 upward, tenths of a dB
	// ****************************************
	localparam logic signed [hvc_pkg::GAIN_W-1:0] TAPER [hvc_pkg::GAIN_STEPS] = '{
		-11'sd595, -11'sd535, -11'sd500, -11'sd475,
		-11'sd455, -11'sd439, -11'sd414, -11'sd395,
		-11'sd365, -11'sd353, -11'sd333, -11'sd317,
		-11'sd304, -11'sd286, -11'sd271, -11'sd263,
		-11'sd247, -11'sd237, -11'sd225, -11'sd217,
		-11'sd205, -11'sd196, -11'sd188, -11'sd178,
		-11'sd170, -11'sd162, -11'sd152, -11'sd145,
		-11'sd137, -11'sd130, -11'sd123, -11'sd116,
		-11'sd109, -11'sd103, -11'sd97, -11'sd90,
		-11'sd85, -11'sd78, -11'sd72, -11'sd67,
		-11'sd61, -11'sd56, -11'sd51, -11'sd45,
		-11'sd41, -11'sd35, -11'sd31, -11'sd26,
		-11'sd21, -11'sd17, -11'sd12, -11'sd8,
		-11'sd3, 11'sd1, 11'sd5, 11'sd9,
		11'sd14, 11'sd17, 11'sd21, 11'sd25,
		11'sd29, 11'sd33, 11'sd36, 11'sd40
	};

	// Registered read; no reset needed, the index is always defined
	always_ff @(posedge clk) begin
		gain <= TAPER[index]; // RL2
	end

endmodule

`default_nettype wire

// File: verilog/hvc_pkg.sv
`default_nettype none

package hvc_pkg;

	// ****************************************
	// Byte framing on the two-wire link
	// ****************************************
	localparam logic [3:0] LAST_BIT = 4'h7;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] FIRST_BIT_COUNT = 4'h1;
	localparam logic [3:0] BIT_COUNT_RESET = 4'h0;
	localparam int ADDR_W = 7;
	localparam int BYTE_W = 8;
	localparam int RW_BIT = 0;

	// ****************************************
	// Register map seen through the link
	// ****************************************
	localparam logic [7:0] VOL_REG_INDEX = 8'h02;
	localparam logic [7:0] VOL_REG_RESET = 8'hc0;
	localparam logic [7:0] PTR_RESET = 8'h00;
	localparam logic [7:0] PTR_STEP = 8'h01;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;
	localparam int MUTE_L_BIT = 7;
	localparam int MUTE_R_BIT = 6;
	localparam int VOL_MSB = 5;
	localparam int VOL_W = 6;

	// ****************************************
	// Gain table, tenths of a dB
	// ****************************************
	localparam int GAIN_W = 11;
	localparam int GAIN_STEPS = 64;
	localparam logic signed [10:0] MUTE_GAIN = -11'sd1000;

	// ****************************************
	// Link sequencing
	// ****************************************
	typedef enum logic [2:0] {
		LK_IDLE,
		LK_ADDR,
		LK_INDEX,
		LK_WRITE,
		LK_READ
	} hvc_link_e;

endpackage

`default_nettype wire

// File: verilog/hvc_serial_target.sv
// Notes on behaviour
// RL1 - Volume only set through the serial bus
// RL2 - Six-bit code selects one of 64 taper steps
// RL3 - Both mutes give -100 dB, else taper
// RL4 - Bytes are eight bits, MSB first
// RL5 - Receiver acknowledges in the following clock
// RL6 - SDA fall/rise with SCL high: start/stop
// RL7 - Data on SDA changes only while SCL low
// RL8 - Controller opens with start, closes with stop
// RL9 - Controller sends address, R/W, awaits acknowledge
// RL10 - Respond only to own 7-bit address
// RL11 - Acknowledge holds SDA low whole period
// RL12 - Controller continues after each acknowledge
// RL13 - Open-drain lines, only pulled low
// RL14 - No limit on bytes per transfer
// RL15 - Controller ends with stop after last byte
// RL16 - Register 2 holds mutes and volume
// RL17 - Reset state muted at lowest step
// RL18 - Multi-byte writes walk to next register
// RL19 - Foreign address: stay released until start
`timescale 1ns/10ps
`default_nettype none

module hvc_serial_target #(
	parameter logic [hvc_pkg::ADDR_W-1:0] TARGET_ADDR = 7'h2a
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic serialClk,
	input wire logic serialDataIn,
	output logic serialDataOut,
	output logic serialDataOe,
	output logic muteLeft,
	output logic muteRight,
	output logic [hvc_pkg::VOL_W-1:0] volumeCode,
	output logic signed [hvc_pkg::GAIN_W-1:0] gainLeft,
	output logic signed [hvc_pkg::GAIN_W-1:0] gainRight,
	output logic settingUpdated,
	output logic targetSelected,
	output logic transferEnded
);

	// ****************************************
	// Helpers
	// ****************************************

	// Read view of the register space; only the volume register is kept
	function automatic logic [7:0] readReg(
		input logic [7:0] index,
		input logic [7:0] volume
	);
		logic [7:0] value;
		value = hvc_pkg::UNMAPPED_READ;
		if (index == hvc_pkg::VOL_REG_INDEX) begin
			value = volume;
		end
		return value;
	endfunction

	// Bit n of a byte counted from the MSB
	function automatic logic msbFirstBit(
		input logic [7:0] value,
		input logic [3:0] n
	);
		logic [3:0] pos;
		pos = hvc_pkg::LAST_BIT - n;
		return value[pos[2:0]];
	endfunction

	// ****************************************
	// Start and stop detection
	// ****************************************

	// Clocked by the data line itself; the clock line is the data here.
	// Toggles instead of flags, so no domain ever has to clear them.
	logic startTgl;
	logic stopTgl;

	always_ff @(negedge serialDataIn or posedge rst) begin
		if (rst) begin
			startTgl <= 1'b0;
		end else if (serialClk) begin
			startTgl <= ~startTgl; // RL6
		end
	end

	always_ff @(posedge serialDataIn or posedge rst) begin
		if (rst) begin
			stopTgl <= 1'b0;
		end else if (serialClk) begin
			stopTgl <= ~stopTgl; // RL6
		end
	end

	// ****************************************
	// Link domain: bit and byte sequencing
	// ****************************************

	// Read raw at the clock edge: bus setup and hold times do the job
	// of a synchroniser, and two link edges of delay would lose bits.
	hvc_pkg::hvc_link_e linkState;
	logic [3:0] bitCnt;
	logic startSeen;
	logic stopSeen;
	logic [6:0] shiftIn;
	logic rwRead;
	logic ackNext;
	logic [7:0] regPtr;
	logic [7:0] txByte;
	logic [7:0] volWord;
	logic updTgl;
	logic selTgl;

	logic startPending;
	logic stopPending;
	logic [7:0] rxByte;
	logic byteEnd;
	logic ackEdge;
	logic addrMatch;

	assign startPending = startTgl != startSeen;
	assign stopPending = stopTgl != stopSeen;
	assign rxByte = {shiftIn, serialDataIn};
	assign byteEnd = !startPending && !stopPending && linkState != hvc_pkg::LK_IDLE
		&& bitCnt == hvc_pkg::LAST_BIT;
	assign ackEdge = !startPending && !stopPending && linkState != hvc_pkg::LK_IDLE
		&& bitCnt == hvc_pkg::BYTE_BITS;
	assign addrMatch = rxByte[hvc_pkg::BYTE_W-1:1] == TARGET_ADDR; // RL10

	always_ff @(posedge serialClk or posedge rst) begin
		if (rst) begin
			linkState <= hvc_pkg::LK_IDLE;
			bitCnt <= hvc_pkg::BIT_COUNT_RESET;
			startSeen <= 1'b0;
			stopSeen <= 1'b0;
		end else begin
			startSeen <= startTgl;
			stopSeen <= stopTgl;
			if (startPending) begin
				// First rising edge after a start carries address bit 6, bit 7 of the byte
				linkState <= hvc_pkg::LK_ADDR; // RL6
				bitCnt <= hvc_pkg::FIRST_BIT_COUNT;
			end else if (stopPending) begin
				linkState <= hvc_pkg::LK_IDLE; // RL6
				bitCnt <= hvc_pkg::BIT_COUNT_RESET;
			end else if (linkState != hvc_pkg::LK_IDLE) begin
				if (ackEdge) begin
					bitCnt <= hvc_pkg::BIT_COUNT_RESET;
					case (linkState)
						hvc_pkg::LK_ADDR: begin
							linkState <= rwRead ? hvc_pkg::LK_READ : hvc_pkg::LK_INDEX;
						end
						hvc_pkg::LK_INDEX: begin
							linkState <= hvc_pkg::LK_WRITE;
						end
						hvc_pkg::LK_WRITE: begin
							linkState <= hvc_pkg::LK_WRITE; // RL14
						end
						hvc_pkg::LK_READ: begin
							// Controller's not-acknowledge ends the read
							linkState <= serialDataIn ? hvc_pkg::LK_IDLE : hvc_pkg::LK_READ;
						end
						default: begin
							linkState <= hvc_pkg::LK_IDLE;
						end
					endcase
				end else begin
					bitCnt <= bitCnt + hvc_pkg::FIRST_BIT_COUNT;
					if (byteEnd && linkState == hvc_pkg::LK_ADDR && !addrMatch) begin
						linkState <= hvc_pkg::LK_IDLE; // RL19
					end
				end
			end
		end
	end

	// ****************************************
	// Link domain: byte assembly and acknowledge decision
	// ****************************************

	always_ff @(posedge serialClk or posedge rst) begin
		if (rst) begin
			shiftIn <= '0;
		end else if (startPending) begin
			shiftIn <= {6'h00, serialDataIn}; // RL4
		end else if (linkState != hvc_pkg::LK_IDLE && bitCnt < hvc_pkg::BYTE_BITS) begin
			shiftIn <= {shiftIn[5:0], serialDataIn}; // RL4
		end
	end

	always_ff @(posedge serialClk or posedge rst) begin
		if (rst) begin
			rwRead <= 1'b0;
			ackNext <= 1'b0;
			selTgl <= 1'b0;
		end else if (startPending) begin
			ackNext <= 1'b0;
		end else if (byteEnd) begin
			case (linkState)
				hvc_pkg::LK_ADDR: begin
					ackNext <= addrMatch; // RL10
					rwRead <= rxByte[hvc_pkg::RW_BIT];
					if (addrMatch) begin
						selTgl <= ~selTgl;
					end
				end
				hvc_pkg::LK_INDEX, hvc_pkg::LK_WRITE: begin
					ackNext <= 1'b1; // RL5
				end
				default: begin
					// During reads the controller acknowledges, not us
					ackNext <= 1'b0;
				end
			endcase
		end
	end

	// ****************************************
	// Link domain: register pointer, volume register, read data
	// ****************************************

	always_ff @(posedge serialClk or posedge rst) begin
		if (rst) begin
			regPtr <= hvc_pkg::PTR_RESET;
			txByte <= hvc_pkg::UNMAPPED_READ;
			volWord <= hvc_pkg::VOL_REG_RESET; // RL17
			updTgl <= 1'b0;
		end else if (byteEnd && linkState == hvc_pkg::LK_INDEX) begin
			regPtr <= rxByte; // RL18
		end else if (byteEnd && linkState == hvc_pkg::LK_WRITE) begin
			if (regPtr == hvc_pkg::VOL_REG_INDEX) begin
				volWord <= rxByte; // RL1
				updTgl <= ~updTgl;
			end
			regPtr <= regPtr + hvc_pkg::PTR_STEP; // RL18
		end else if (ackEdge && linkState == hvc_pkg::LK_ADDR && rwRead) begin
			txByte <= readReg(regPtr, volWord);
			regPtr <= regPtr + hvc_pkg::PTR_STEP;
		end else if (ackEdge && linkState == hvc_pkg::LK_READ && !serialDataIn) begin
			txByte <= readReg(regPtr, volWord);
			regPtr <= regPtr + hvc_pkg::PTR_STEP;
		end
	end

	// ****************************************
	// Link domain: data line drive
	// ****************************************

	// Falling edge only, so our drive never moves while the clock is high
	always_ff @(negedge serialClk or posedge rst) begin
		if (rst) begin
			serialDataOe <= 1'b0;
		end else if (startPending) begin
			serialDataOe <= 1'b0; // RL7
		end else begin
			case (linkState)
				hvc_pkg::LK_ADDR, hvc_pkg::LK_INDEX, hvc_pkg::LK_WRITE: begin
					serialDataOe <= ackNext && bitCnt == hvc_pkg::BYTE_BITS; // RL11
				end
				hvc_pkg::LK_READ: begin
					serialDataOe <= bitCnt < hvc_pkg::BYTE_BITS
						&& !msbFirstBit(txByte, bitCnt); // RL7
				end
				default: begin
					serialDataOe <= 1'b0; // RL19
				end
			endcase
		end
	end

	// Wired-AND: the line is only ever pulled low
	always_ff @(posedge sys_clk) begin
		serialDataOut <= 1'b0; // RL13
	end

	// ****************************************
	// System domain: event crossings
	// ****************************************

	// Toggles pass two flip-flops; the word behind the update toggle is
	// held for at least a byte time, far longer than the crossing takes.
	logic [2:0] tglMeta;
	logic [2:0] tglSync;
	logic [2:0] tglPrev;
	logic [2:0] tglEvent;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			tglMeta <= 3'h0;
			tglSync <= 3'h0;
			tglPrev <= 3'h0;
		end else begin
			tglMeta <= {stopTgl, selTgl, updTgl};
			tglSync <= tglMeta;
			tglPrev <= tglSync;
		end
	end

	assign tglEvent = tglSync ^ tglPrev;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			settingUpdated <= 1'b0;
			targetSelected <= 1'b0;
			transferEnded <= 1'b0;
		end else begin
			settingUpdated <= tglEvent[0];
			targetSelected <= tglEvent[1];
			transferEnded <= tglEvent[2];
		end
	end

	// ****************************************
	// System domain: settings and gain
	// ****************************************

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			muteLeft <= hvc_pkg::VOL_REG_RESET[hvc_pkg::MUTE_L_BIT]; // RL17
			muteRight <= hvc_pkg::VOL_REG_RESET[hvc_pkg::MUTE_R_BIT];
			volumeCode <= hvc_pkg::VOL_REG_RESET[hvc_pkg::VOL_MSB:0];
		end else if (tglEvent[0]) begin
			muteLeft <= volWord[hvc_pkg::MUTE_L_BIT]; // RL16
			muteRight <= volWord[hvc_pkg::MUTE_R_BIT];
			volumeCode <= volWord[hvc_pkg::VOL_MSB:0];
		end
	end

	logic signed [hvc_pkg::GAIN_W-1:0] taperGain;
	logic muteLeftLag;
	logic muteRightLag;

	hvc_gain_rom u_rom (
		.clk(sys_clk),
		.index(volumeCode),
		.gain(taperGain)
	);

	// Mutes delayed to line up with the registered table read
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			muteLeftLag <= 1'b1;
			muteRightLag <= 1'b1;
			gainLeft <= hvc_pkg::MUTE_GAIN;
			gainRight <= hvc_pkg::MUTE_GAIN;
		end else begin
			muteLeftLag <= muteLeft;
			muteRightLag <= muteRight;
			gainLeft <= muteLeftLag ? hvc_pkg::MUTE_GAIN : taperGain; // RL3
			gainRight <= muteRightLag ? hvc_pkg::MUTE_GAIN : taperGain; // RL3
		end
	end

endmodule

`default_nettype wire
